// ==== inc/pfp_pkg.sv ====
// Package for the processor status word and next-instruction pointer block.
// Assumes a single 200 MHz clock domain and a synchronous active-low reset.
package pfp_pkg;
   // Status word bit positions
   localparam int unsigned BIT_CARRY  = 0;
   localparam int unsigned BIT_RSV1   = 1;
   localparam int unsigned BIT_PARITY = 2;
   localparam int unsigned BIT_HALF   = 4;
   localparam int unsigned BIT_ZERO   = 6;
   localparam int unsigned BIT_SIGN   = 7;
   localparam int unsigned BIT_STEP   = 8;
   localparam int unsigned BIT_INTEN  = 9;
   localparam int unsigned BIT_DIR    = 10;
   localparam int unsigned BIT_OVF    = 11;
   localparam int unsigned BIT_IOPL0  = 12;
   localparam int unsigned BIT_NEST   = 14;
   localparam int unsigned BIT_RESUME = 16;
   localparam int unsigned BIT_V86    = 17;
   localparam int unsigned BIT_ALIGN  = 18;
   localparam int unsigned BIT_VINT   = 19;
   localparam int unsigned BIT_VPEND  = 20;
   localparam int unsigned BIT_PROBE  = 21;

   // Reset value: only reserved bit 1 set
   localparam logic [31:0] PSW_RESET = 32'h0000_0002;
   // Bits that exist; reserved bits 3,5,15,22..31 read zero, bit 1 reads one
   localparam logic [31:0] PSW_IMPL  = 32'h003f_7fd5;
   // Bits a flag pop may load before privilege filtering
   localparam logic [31:0] POP_MASK  = 32'h003f_7fd5;
   localparam logic [1:0]  PRIV_TOP  = 2'h0;

   // Operation codes presented by the core
   typedef enum logic [4:0] {
      OP_NONE      = 5'h00,
      OP_ADD       = 5'h01,
      OP_ADC       = 5'h02,
      OP_SUB       = 5'h03,
      OP_SBB       = 5'h04,
      OP_LOGIC     = 5'h05,
      OP_SET_CARRY = 5'h06,
      OP_CLR_CARRY = 5'h07,
      OP_CMP_CARRY = 5'h08,
      OP_BIT_TEST  = 5'h09,
      OP_SET_DIR   = 5'h0a,
      OP_CLR_DIR   = 5'h0b,
      OP_POP_FLAGS = 5'h0c,
      OP_INT_RET   = 5'h0d,
      OP_SET_STEP  = 5'h0e,
      OP_CLR_STEP  = 5'h0f,
      OP_SET_INTEN = 5'h10,
      OP_CLR_INTEN = 5'h11,
      OP_TASK_LINK = 5'h12,
      OP_TASK_FREE = 5'h13
   } pfp_op_t;

   // Pointer update kinds
   typedef enum logic [1:0] {
      PC_HOLD   = 2'b00,
      PC_SEQ    = 2'b01,
      PC_XFER   = 2'b10
   } pfp_pc_t;

   // Operation request from the core
   typedef struct packed {
      logic        valid;
      pfp_op_t     op;
      logic [31:0] a;
      logic [31:0] b;
      logic [4:0]  bit_sel;
      logic [31:0] pop_word;
   } pfp_req_t;

   // Arithmetic result and its flags
   typedef struct packed {
      logic [31:0] result;
      logic        carry;
      logic        parity;
      logic        half;
      logic        zero;
      logic        sign;
      logic        ovf;
   } pfp_alu_t;

   // Whole state of the block
   typedef struct packed {
      logic [31:0] psw;
      logic [31:0] nip;
      logic [31:0] result;
   } pfp_state_t;
endpackage

// ==== logic/pfp_alu.sv ====
// Adder and flag generator for the status word block.
// Assumes operands and carry-in are stable for the cycle; purely combinational.
`timescale 1ns/1ps
module pfp_alu #(
   parameter int unsigned W = 32
) (
   input  wire logic [W-1:0]     a_i,
   input  wire logic [W-1:0]     b_i,
   input  wire logic             sub_i,
   input  wire logic             cin_i,
   input  wire logic             logic_i,
   output pfp_pkg::pfp_alu_t     out_o
);
   // Elaboration check: flag positions assume a 32-bit word
   if (W != 32)
   begin : g_bad_width
      $error("pfp_alu supports W = 32 only");
   end

   logic [W:0]   sum;
   logic [W-1:0] bop;
   logic [4:0]   low;
   logic         cb;

   // Subtract as add of inverse; borrow is the inverted carry
   always_comb
   begin
      cb    = sub_i ? ~cin_i : cin_i;
      bop   = sub_i ? ~b_i : b_i;
      sum   = {1'b0, a_i} + {1'b0, bop} + {{W{1'b0}}, cb};
      low   = {1'b0, a_i[3:0]} + {1'b0, bop[3:0]} + {4'h0, cb};
      out_o.result = logic_i ? (a_i & b_i) : sum[W-1:0];
      out_o.carry  = logic_i ? 1'b0 : (sum[W] ^ sub_i);                 // [RL1]
      out_o.half   = logic_i ? 1'b0 : (low[4] ^ sub_i);                 // [RL3]
      out_o.parity = ~^out_o.result[7:0];                               // [RL2]
      out_o.zero   = (out_o.result == '0);                              // [RL4]
      out_o.sign   = out_o.result[W-1];                                 // [RL5]
      out_o.ovf    = logic_i ? 1'b0 :
                     ((a_i[W-1] == bop[W-1]) && (sum[W-1] != a_i[W-1])); // [RL6]
   end
endmodule

// ==== logic/pfp_flags.sv ====
// Processor status word and next-instruction pointer.
// Assumes the core issues one request per cycle and sequences control flow.
// What this block does
// [RL1] Carry out of top bit sets carry
// [RL2] Even ones in low byte set parity
// [RL3] Carry out of bit 3 sets half-carry
// [RL4] Zero result sets zero flag
// [RL5] Sign flag copies result top bit
// [RL6] Signed overflow sets overflow flag
// [RL7] Only carry has set, clear, complement, bit-copy
// [RL8] Add/subtract with carry consume carry
// [RL9] Direction bit picks string step sign
// [RL10] Interrupt enable gates maskable interrupts
// [RL11] Step bit enables single-step mode
// [RL12] I/O allowed when privilege <= I/O level
// [RL13] I/O level changes only by pop/return at top privilege
// [RL14] Nesting bit tracks linked task
// [RL15] Resume bit steers debug exception response
// [RL16] Mode bit selects virtual-8086 mode
// [RL17] Alignment checks need both enable bits
// [RL18] Virtual interrupt mirrors enable; pending software-only
// [RL19] Probe bit is software toggleable
// [RL20] Pointer moves sequentially or by transfer only
// [RL21] Flow follows pointer, not prefetch address
// [RL22] Reset loads word with only bit 1 set
// [RL23] Reserved bits carry no function
// [RL24] Undefined flags keep their value
`timescale 1ns/1ps
module pfp_flags #(
   parameter int unsigned W = 32
) (
   input  wire logic               clk_i,
   input  wire logic               rst_n_i,
   input  pfp_pkg::pfp_req_t       req_i,
   input  wire logic [1:0]         cur_priv_i,
   input  wire logic               vme_i,
   input  wire logic               align_mask_i,
   input  wire logic               intr_req_i,
   input  wire logic               io_req_i,
   input  wire logic               debug_exc_i,
   input  pfp_pkg::pfp_pc_t        pc_kind_i,
   input  wire logic [W-1:0]       pc_step_i,
   input  wire logic [W-1:0]       pc_target_i,
   output logic [31:0]             psw_o,
   output logic [W-1:0]            nip_o,
   output logic [W-1:0]            result_o,
   output logic                    intr_take_o,
   output logic                    io_allow_o,
   output logic                    step_mode_o,
   output logic                    string_dec_o,
   output logic                    v86_mode_o,
   output logic                    align_chk_o,
   output logic                    debug_take_o,
   output logic                    vint_pending_o
);
   // Elaboration check: status word layout is fixed at 32 bits
   if (W != 32)
   begin : g_bad_width
      $error("pfp_flags supports W = 32 only");
   end

   pfp_pkg::pfp_state_t st_q;
   pfp_pkg::pfp_state_t st_d;
   pfp_pkg::pfp_alu_t   alu;
   logic                is_sub;
   logic                use_cin;
   logic                is_arith;
   logic                is_logic;
   logic                is_pop;
   logic [31:0]         popw;
   logic [31:0]         keep;

   // Decode operand routing for the adder
   always_comb
   begin
      is_sub   = (req_i.op == pfp_pkg::OP_SUB) || (req_i.op == pfp_pkg::OP_SBB);
      use_cin  = (req_i.op == pfp_pkg::OP_ADC) || (req_i.op == pfp_pkg::OP_SBB); // [RL8]
      is_logic = (req_i.op == pfp_pkg::OP_LOGIC);
      is_pop   = req_i.valid && ((req_i.op == pfp_pkg::OP_POP_FLAGS) ||
                 (req_i.op == pfp_pkg::OP_INT_RET));
      is_arith = req_i.valid && (is_logic || use_cin ||
                 (req_i.op == pfp_pkg::OP_ADD) || (req_i.op == pfp_pkg::OP_SUB));
   end

   pfp_alu #(
      .W(W)
   ) u_alu (
      .a_i    (req_i.a),
      .b_i    (req_i.b),
      .sub_i  (is_sub),
      .cin_i  (use_cin & st_q.psw[pfp_pkg::BIT_CARRY]),     // [RL8]
      .logic_i(is_logic),
      .out_o  (alu)
   );

   // Next-state: flags held unless the operation defines them
   always_comb
   begin
      st_d = st_q;                                          // [RL24]
      popw = 32'h0000_0000;
      keep = 32'h0000_0000;
      if (is_arith)
      begin
         st_d.result                       = alu.result;
         st_d.psw[pfp_pkg::BIT_CARRY]      = alu.carry;    // [RL1]
         st_d.psw[pfp_pkg::BIT_PARITY]     = alu.parity;   // [RL2]
         st_d.psw[pfp_pkg::BIT_HALF]       = alu.half;     // [RL3]
         st_d.psw[pfp_pkg::BIT_ZERO]       = alu.zero;     // [RL4]
         st_d.psw[pfp_pkg::BIT_SIGN]       = alu.sign;     // [RL5]
         st_d.psw[pfp_pkg::BIT_OVF]        = alu.ovf;      // [RL6]
      end
      else if (req_i.valid)
      begin
         case (req_i.op)
            pfp_pkg::OP_SET_CARRY: st_d.psw[pfp_pkg::BIT_CARRY] = 1'b1;  // [RL7]
            pfp_pkg::OP_CLR_CARRY: st_d.psw[pfp_pkg::BIT_CARRY] = 1'b0;  // [RL7]
            pfp_pkg::OP_CMP_CARRY: st_d.psw[pfp_pkg::BIT_CARRY] =
                                   ~st_q.psw[pfp_pkg::BIT_CARRY];        // [RL7]
            pfp_pkg::OP_BIT_TEST:  st_d.psw[pfp_pkg::BIT_CARRY] =
                                   req_i.a[req_i.bit_sel];               // [RL7]
            pfp_pkg::OP_SET_DIR:   st_d.psw[pfp_pkg::BIT_DIR] = 1'b1;    // [RL9]
            pfp_pkg::OP_CLR_DIR:   st_d.psw[pfp_pkg::BIT_DIR] = 1'b0;    // [RL9]
            pfp_pkg::OP_SET_STEP:  st_d.psw[pfp_pkg::BIT_STEP] = 1'b1;   // [RL11]
            pfp_pkg::OP_CLR_STEP:  st_d.psw[pfp_pkg::BIT_STEP] = 1'b0;   // [RL11]
            pfp_pkg::OP_SET_INTEN: st_d.psw[pfp_pkg::BIT_INTEN] = 1'b1;  // [RL10]
            pfp_pkg::OP_CLR_INTEN: st_d.psw[pfp_pkg::BIT_INTEN] = 1'b0;  // [RL10]
            pfp_pkg::OP_TASK_LINK: st_d.psw[pfp_pkg::BIT_NEST] = 1'b1;   // [RL14]
            pfp_pkg::OP_TASK_FREE: st_d.psw[pfp_pkg::BIT_NEST] = 1'b0;   // [RL14]
            pfp_pkg::OP_POP_FLAGS,
            pfp_pkg::OP_INT_RET:
            begin
               // I/O level field is protected below top privilege
               keep = ~pfp_pkg::POP_MASK;
               if (cur_priv_i != pfp_pkg::PRIV_TOP)
               begin
                  keep[pfp_pkg::BIT_IOPL0 +: 2] = 2'b11;                 // [RL13]
               end
               popw = (req_i.pop_word & ~keep) | (st_q.psw & keep);
               // Probe and pending bits load freely from software
               st_d.psw = (popw & pfp_pkg::PSW_IMPL) | pfp_pkg::PSW_RESET; // [RL19] [RL23]
            end
            default:
            begin
               st_d.psw = st_q.psw;                                       // [RL24]
            end
         endcase
      end
      // Virtual interrupt copy follows enable when extensions are on
      if (vme_i)
      begin
         st_d.psw[pfp_pkg::BIT_VINT] = st_d.psw[pfp_pkg::BIT_INTEN];       // [RL18]
      end
      // Resume bit is consumed by the debug exception it suppresses;
      // a pop in the same cycle wins so a reloaded bit is not lost
      if (debug_exc_i && st_q.psw[pfp_pkg::BIT_RESUME] && !is_pop)
      begin
         st_d.psw[pfp_pkg::BIT_RESUME] = 1'b0;                             // [RL15]
      end
      // Pointer only advances or takes a transfer target
      case (pc_kind_i)
         pfp_pkg::PC_SEQ:  st_d.nip = st_q.nip + pc_step_i;                // [RL20]
         pfp_pkg::PC_XFER: st_d.nip = pc_target_i;                         // [RL20]
         default:          st_d.nip = st_q.nip;
      endcase
   end

   // Single state register
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         st_q.psw    <= pfp_pkg::PSW_RESET;                                // [RL22]
         st_q.nip    <= '0;
         st_q.result <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // Control outputs derived from stored word
   always_comb
   begin
      psw_o          = st_q.psw;
      nip_o          = st_q.nip;                                           // [RL21]
      result_o       = st_q.result;
      intr_take_o    = intr_req_i & st_q.psw[pfp_pkg::BIT_INTEN];         // [RL10]
      io_allow_o     = io_req_i &
                       (cur_priv_i <= st_q.psw[pfp_pkg::BIT_IOPL0 +: 2]); // [RL12]
      step_mode_o    = st_q.psw[pfp_pkg::BIT_STEP];                       // [RL11]
      string_dec_o   = st_q.psw[pfp_pkg::BIT_DIR];                        // [RL9]
      v86_mode_o     = st_q.psw[pfp_pkg::BIT_V86];                        // [RL16]
      align_chk_o    = st_q.psw[pfp_pkg::BIT_ALIGN] & align_mask_i;      // [RL17]
      debug_take_o   = debug_exc_i & ~st_q.psw[pfp_pkg::BIT_RESUME];     // [RL15]
      vint_pending_o = vme_i & st_q.psw[pfp_pkg::BIT_VPEND];             // [RL18]
   end

   // Checks
   sequence carry_set_s;
      req_i.valid && req_i.op == pfp_pkg::OP_SET_CARRY;
   endsequence

   reset_word_a: assert property (@(posedge clk_i) // [RL22]
      !rst_n_i |=> psw_o == pfp_pkg::PSW_RESET)
      else $error("status word wrong after reset");
   carry_set_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL7]
      carry_set_s |=> psw_o[pfp_pkg::BIT_CARRY])
      else $error("carry not set");
   zero_flag_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL4]
      is_arith |=> psw_o[pfp_pkg::BIT_ZERO] == (result_o == 32'h0000_0000))
      else $error("zero flag mismatch");
   sign_flag_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL5]
      is_arith |=> psw_o[pfp_pkg::BIT_SIGN] == result_o[31])
      else $error("sign flag mismatch");
   parity_flag_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL2]
      is_arith |=> psw_o[pfp_pkg::BIT_PARITY] == ~^result_o[7:0])
      else $error("parity flag mismatch");
   intr_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL10]
      intr_take_o |-> psw_o[pfp_pkg::BIT_INTEN])
      else $error("interrupt taken while disabled");
   io_privilege_level_guard_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL13]
      cur_priv_i != pfp_pkg::PRIV_TOP |=>
      $stable(psw_o[pfp_pkg::BIT_IOPL0 +: 2]))
      else $error("I/O level changed below top privilege");
   io_allow_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL12]
      io_allow_o |-> cur_priv_i <= psw_o[pfp_pkg::BIT_IOPL0 +: 2])
      else $error("I/O allowed above level");
   ptr_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL20]
      pc_kind_i == pfp_pkg::PC_HOLD |=> $stable(nip_o))
      else $error("pointer moved without cause");
   carry_keep_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL24]
      !req_i.valid && !vme_i ##1 1'b1 |-> $stable(psw_o[pfp_pkg::BIT_CARRY]))
      else $error("carry changed without operation");
   align_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL17]
      align_chk_o |-> psw_o[pfp_pkg::BIT_ALIGN] && align_mask_i)
      else $error("alignment check without both enables");

   // Result flags rebuilt from the stored adder result and the raw operands,
   // so a flag is checked against the sum, not against an independent model
   sequence add_s;
      req_i.valid && req_i.op == pfp_pkg::OP_ADD;
   endsequence

   sequence adc_s;
      req_i.valid && req_i.op == pfp_pkg::OP_ADC;
   endsequence

   carry_add_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL1]
      add_s |=> psw_o[pfp_pkg::BIT_CARRY] == (result_o < $past(req_i.a)))
      else $error("carry flag mismatch");
   half_add_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL3]
      add_s |=> psw_o[pfp_pkg::BIT_HALF] == (result_o[3:0] < $past(req_i.a[3:0])))
      else $error("half-carry flag mismatch");
   ovf_add_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL6]
      add_s |=> psw_o[pfp_pkg::BIT_OVF] == ($past(req_i.a[31]) == $past(req_i.b[31]) &&
                result_o[31] != $past(req_i.a[31])))
      else $error("overflow flag mismatch");
   carry_chain_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL8]
      adc_s |=> result_o ==
                $past(req_i.a) + $past(req_i.b) + $past(psw_o[pfp_pkg::BIT_CARRY]))
      else $error("stored carry not consumed");

   // Dedicated set and clear ops on the control bits
   sequence dir_op_s;
      req_i.valid && (req_i.op == pfp_pkg::OP_SET_DIR || req_i.op == pfp_pkg::OP_CLR_DIR);
   endsequence

   sequence step_op_s;
      req_i.valid && (req_i.op == pfp_pkg::OP_SET_STEP || req_i.op == pfp_pkg::OP_CLR_STEP);
   endsequence

   sequence nest_op_s;
      req_i.valid && (req_i.op == pfp_pkg::OP_TASK_LINK || req_i.op == pfp_pkg::OP_TASK_FREE);
   endsequence

   dir_op_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL9]
      dir_op_s |=> string_dec_o == ($past(req_i.op) == pfp_pkg::OP_SET_DIR))
      else $error("direction bit not set or cleared");
   step_op_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL11]
      step_op_s |=> step_mode_o == ($past(req_i.op) == pfp_pkg::OP_SET_STEP))
      else $error("step bit not set or cleared");
   nest_op_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL14]
      nest_op_s |=> psw_o[pfp_pkg::BIT_NEST] == ($past(req_i.op) == pfp_pkg::OP_TASK_LINK))
      else $error("nesting bit not set or cleared");
   resume_use_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL15]
      debug_exc_i && psw_o[pfp_pkg::BIT_RESUME] && !is_pop |=> !psw_o[pfp_pkg::BIT_RESUME])
      else $error("resume bit not consumed");

   // Software-loaded bits follow the popped word and nothing else
   v86_load_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL16]
      is_pop |=> v86_mode_o == $past(req_i.pop_word[pfp_pkg::BIT_V86]))
      else $error("mode bit not loaded by pop");
   probe_load_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL19]
      is_pop |=> psw_o[pfp_pkg::BIT_PROBE] == $past(req_i.pop_word[pfp_pkg::BIT_PROBE]))
      else $error("probe bit not loaded by pop");
   io_privilege_level_load_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL13]
      is_pop && cur_priv_i == pfp_pkg::PRIV_TOP |=>
      psw_o[pfp_pkg::BIT_IOPL0 +: 2] == $past(req_i.pop_word[pfp_pkg::BIT_IOPL0 +: 2]))
      else $error("I/O level not loaded at top privilege");
   sw_bits_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL18] [RL19]
      !is_pop |=> $stable(psw_o[pfp_pkg::BIT_VPEND +: 2]))
      else $error("software-only bits changed without pop");
   vint_mirror_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL18]
      vme_i |=> psw_o[pfp_pkg::BIT_VINT] == psw_o[pfp_pkg::BIT_INTEN])
      else $error("virtual interrupt bit not mirroring enable");
   rsvd_bits_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL23]
      (psw_o & ~pfp_pkg::PSW_IMPL) == pfp_pkg::PSW_RESET)
      else $error("reserved bits disturbed");

   // Pointer moves only by the step or the transfer target
   ptr_xfer_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL20]
      pc_kind_i == pfp_pkg::PC_XFER |=> nip_o == $past(pc_target_i))
      else $error("pointer missed transfer target");
   ptr_seq_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL20]
      pc_kind_i == pfp_pkg::PC_SEQ |=> nip_o == $past(nip_o) + $past(pc_step_i))
      else $error("pointer missed sequential step");
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the status word and next-instruction pointer block.
// Assumes the package and design files are compiled first; one clock domain.
`timescale 1ns/1ps
module tb_top;
   logic              clk_i;
   logic              rst_n_i;
   pfp_pkg::pfp_req_t req_i;
   logic [1:0]        cur_priv_i;
   logic              vme_i;
   logic              align_mask_i;
   logic              intr_req_i;
   logic              io_req_i;
   logic              debug_exc_i;
   pfp_pkg::pfp_pc_t  pc_kind_i;
   logic [31:0]       pc_step_i;
   logic [31:0]       pc_target_i;
   logic [31:0]       psw_o;
   logic [31:0]       nip_o;
   logic [31:0]       result_o;
   logic              intr_take_o;
   logic              io_allow_o;
   logic              step_mode_o;
   logic              string_dec_o;
   logic              v86_mode_o;
   logic              align_chk_o;
   logic              debug_take_o;
   logic              vint_pending_o;
   int                n_fail;
   int                check_count;

   pfp_flags pfp_flags_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req_i),
      .cur_priv_i(cur_priv_i), .vme_i(vme_i), .align_mask_i(align_mask_i),
      .intr_req_i(intr_req_i), .io_req_i(io_req_i), .debug_exc_i(debug_exc_i),
      .pc_kind_i(pc_kind_i), .pc_step_i(pc_step_i), .pc_target_i(pc_target_i),
      .psw_o(psw_o), .nip_o(nip_o), .result_o(result_o), .intr_take_o(intr_take_o),
      .io_allow_o(io_allow_o), .step_mode_o(step_mode_o), .string_dec_o(string_dec_o),
      .v86_mode_o(v86_mode_o), .align_chk_o(align_chk_o), .debug_take_o(debug_take_o),
      .vint_pending_o(vint_pending_o));

   // 200 MHz clock
   initial clk_i = 1'b0;
   always #2.5 clk_i = ~clk_i;

   // Compare tasks, four-state so an unknown never matches
   task automatic chk32(input string name, input logic [31:0] exp, input logic [31:0] seen);
      check_count++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask

   task automatic chk1(input string name, input logic exp, input logic seen);
      check_count++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("unexpected %s: expected %b, seen %b", name, exp, seen);
      end
   endtask

   // Every drive lands 1 ns after a rising edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   // Valid stays up so ops run back to back; idle drops it
   task automatic issue(input pfp_pkg::pfp_op_t op, input logic [31:0] a,
                        input logic [31:0] b, input logic [4:0] sel, input logic [31:0] pw);
      req_i = '{1'b1, op, a, b, sel, pw};
      tick(1);
   endtask

   task automatic idle();
      req_i.valid = 1'b0;
      tick(1);
   endtask

   // Mid-run reset before each scenario gives a known word
   task automatic do_reset();
      req_i.valid = 1'b0;
      rst_n_i = 1'b0;
      tick(3);
      rst_n_i = 1'b1;
   endtask

   task automatic s_reset();
      do_reset();
      chk32("psw", 32'h0000_0002, psw_o);
      chk32("nip", 32'h0000_0000, nip_o);
   endtask

   task automatic s_arith();
      do_reset();
      issue(pfp_pkg::OP_ADD, 32'hffff_ffff, 32'h1, 5'h0, 32'h0);
      chk32("result", 32'h0, result_o);
      chk32("psw", 32'h0000_0057, psw_o);
      issue(pfp_pkg::OP_LOGIC, 32'hf0, 32'h3c, 5'h0, 32'h0);
      chk32("psw", 32'h0000_0006, psw_o);
      issue(pfp_pkg::OP_ADD, 32'h7fff_ffff, 32'h1, 5'h0, 32'h0);
      chk32("psw", 32'h0000_0896, psw_o);
      issue(pfp_pkg::OP_SUB, 32'h0, 32'h1, 5'h0, 32'h0);
      chk32("psw", 32'h0000_0097, psw_o);
      issue(pfp_pkg::OP_SBB, 32'h5, 32'h2, 5'h0, 32'h0);
      chk32("result", 32'h2, result_o);
      chk32("psw", 32'h0000_0002, psw_o);
      issue(pfp_pkg::OP_ADD, 32'hffff_ffff, 32'h1, 5'h0, 32'h0);
      issue(pfp_pkg::OP_ADC, 32'h1, 32'h1, 5'h0, 32'h0);
      chk32("result", 32'h3, result_o);
      issue(pfp_pkg::OP_NONE, 32'h9, 32'h9, 5'h0, 32'h0);
      chk32("psw", 32'h0000_0006, psw_o);
      idle();
   endtask

   task automatic s_carry();
      pfp_pkg::pfp_op_t ops [6];
      logic [5:0]       cy;
      ops = '{pfp_pkg::OP_SET_CARRY, pfp_pkg::OP_CMP_CARRY, pfp_pkg::OP_CMP_CARRY,
              pfp_pkg::OP_CLR_CARRY, pfp_pkg::OP_BIT_TEST, pfp_pkg::OP_BIT_TEST};
      cy = 6'b010101;
      do_reset();
      // Bit test takes bit 4 first, then bit 3, of the same operand
      for (int i = 0; i < 6; i++)
      begin
         issue(ops[i], 32'h10, 32'h0, (i == 5) ? 5'h3 : 5'h4, 32'h0);
         chk32("psw", {31'h1, cy[i]}, psw_o);
      end
      idle();
   endtask

   task automatic s_ctrl();
      do_reset();
      issue(pfp_pkg::OP_SET_DIR, 32'h0, 32'h0, 5'h0, 32'h0);
      chk32("psw", 32'h0000_0402, psw_o);
      chk1("string_dec", 1'b1, string_dec_o);
      issue(pfp_pkg::OP_CLR_DIR, 32'h0, 32'h0, 5'h0, 32'h0);
      chk1("string_dec", 1'b0, string_dec_o);
      issue(pfp_pkg::OP_SET_STEP, 32'h0, 32'h0, 5'h0, 32'h0);
      chk1("step_mode", 1'b1, step_mode_o);
      issue(pfp_pkg::OP_CLR_STEP, 32'h0, 32'h0, 5'h0, 32'h0);
      chk1("step_mode", 1'b0, step_mode_o);
      issue(pfp_pkg::OP_TASK_LINK, 32'h0, 32'h0, 5'h0, 32'h0);
      chk32("psw", 32'h0000_4002, psw_o);
      issue(pfp_pkg::OP_TASK_FREE, 32'h0, 32'h0, 5'h0, 32'h0);
      chk32("psw", 32'h0000_0002, psw_o);
      intr_req_i = 1'b1;
      idle();
      chk1("intr_take", 1'b0, intr_take_o);
      issue(pfp_pkg::OP_SET_INTEN, 32'h0, 32'h0, 5'h0, 32'h0);
      chk1("intr_take", 1'b1, intr_take_o);
      vme_i = 1'b1;
      idle();
      tick(1);
      chk1("vint", 1'b1, psw_o[pfp_pkg::BIT_VINT]);
      issue(pfp_pkg::OP_CLR_INTEN, 32'h0, 32'h0, 5'h0, 32'h0);
      chk1("intr_take", 1'b0, intr_take_o);
      idle();
      chk1("vint", 1'b0, psw_o[pfp_pkg::BIT_VINT]);
      vme_i = 1'b0;
      intr_req_i = 1'b0;
   endtask

   task automatic s_priv();
      do_reset();
      cur_priv_i = 2'h3;
      issue(pfp_pkg::OP_POP_FLAGS, 32'h0, 32'h0, 5'h0, 32'hffff_ffff);
      idle();
      // Virtual interrupt bit is left out: it tracks enable only under vme
      chk32("psw", 32'h0037_4fd7, psw_o & 32'hfff7_ffff);
      chk1("v86", 1'b1, v86_mode_o);
      chk1("align", 1'b0, align_chk_o);
      align_mask_i = 1'b1;
      vme_i = 1'b1;
      io_req_i = 1'b1;
      debug_exc_i = 1'b1;
      tick(1);
      chk1("align", 1'b1, align_chk_o);
      chk1("vint_pending", 1'b1, vint_pending_o);
      chk1("io_allow", 1'b0, io_allow_o);
      tick(1);
      chk1("resume", 1'b0, psw_o[pfp_pkg::BIT_RESUME]);
      chk1("debug_take", 1'b1, debug_take_o);
      debug_exc_i = 1'b0;
      cur_priv_i = 2'h0;
      issue(pfp_pkg::OP_POP_FLAGS, 32'h0, 32'h0, 5'h0, 32'h0000_2000);
      idle();
      chk32("psw", 32'h0000_2002, psw_o);
      chk1("v86", 1'b0, v86_mode_o);
      cur_priv_i = 2'h3;
      tick(1);
      chk1("io_allow", 1'b0, io_allow_o);
      cur_priv_i = 2'h2;
      tick(1);
      chk1("io_allow", 1'b1, io_allow_o);
      cur_priv_i = 2'h3;
      issue(pfp_pkg::OP_INT_RET, 32'h0, 32'h0, 5'h0, 32'h0020_0000);
      idle();
      chk32("psw", 32'h0020_2002, psw_o);
      {align_mask_i, vme_i, io_req_i, cur_priv_i} = '0;
   endtask

   task automatic s_ptr();
      do_reset();
      pc_step_i = 32'h4;
      pc_kind_i = pfp_pkg::PC_SEQ;
      tick(2);
      chk32("nip", 32'h8, nip_o);
      pc_target_i = 32'h100;
      pc_kind_i = pfp_pkg::PC_XFER;
      tick(1);
      chk32("nip", 32'h100, nip_o);
      pc_kind_i = pfp_pkg::PC_HOLD;
      issue(pfp_pkg::OP_ADD, 32'h1, 32'h1, 5'h0, 32'h0);
      idle();
      chk32("nip", 32'h100, nip_o);
      pc_step_i = 32'h10;
      pc_kind_i = pfp_pkg::PC_SEQ;
      tick(1);
      pc_kind_i = pfp_pkg::PC_HOLD;
      chk32("nip", 32'h110, nip_o);
   endtask

   task automatic stop_test();
      $display("checks %0d, mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Hang guard well above the whole run
   initial
   begin
      #500000;
      n_fail++;
      stop_test();
   end

   // Main sequence
   initial
   begin
      {n_fail, check_count} = '0;
      rst_n_i = 1'b0;
      req_i = '0;
      {cur_priv_i, vme_i, align_mask_i, intr_req_i, io_req_i, debug_exc_i} = '0;
      pc_kind_i = pfp_pkg::PC_HOLD;
      {pc_step_i, pc_target_i} = '0;
      tick(3);
      s_reset();
      s_arith();
      s_carry();
      s_ctrl();
      s_priv();
      s_ptr();
      stop_test();
   end
endmodule
